// [core/cpm_ctrl.sv]
// Purpose: Clock source selection, prescalers, gating and power modes.
// Assumes: Oscillators report ready as pins; clocks are modelled as enables
//          and selects that drive the analog clock tree.
// Notes:   Register port: read data stand one cycle after the read strobe.
`timescale 1ns/1ps
`include "cpm_consts.svh"

module cpm_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        fast_crystal_osc_rdy,
  input  wire logic        fast_internal_osc_rdy,
  input  wire logic        multispeed_internal_osc_rdy,
  input  wire logic        pll_rdy,
  input  wire logic        crystal_fail,
  input  wire logic [15:0] external_interrupt_lines,
  input  wire logic        supply_voltage_monitor,
  input  wire logic [1:0]  comparator_evt,
  input  wire logic [3:0]  rtc_evt,
  input  wire logic        usb_wakeup,
  input  wire logic        cpu_irq_evt,
  input  wire logic        cpu_sleep_req,
  output logic [1:0]       sys_clk_sel,
  output logic [2:0]       ms_osc_range,
  output logic             fast_crystal_osc_en,
  output logic             fast_internal_osc_en,
  output logic             multispeed_internal_osc_en,
  output logic             slow_crystal_osc_en,
  output logic             slow_internal_osc_en,
  output logic             pll_en,
  output logic             usb_clk_en,
  output logic [1:0]       rtc_clk_sel,
  output logic [2:0]       ahb_div,
  output logic [2:0]       apb_fast_div,
  output logic [2:0]       apb_slow_div,
  output logic             cpu_clk_en,
  output logic [15:0]      periph_clk_en,
  output logic             mem_clk_en,
  output logic [2:0]       clock_output_pin_sel,
  output logic             regulator_lp,
  output logic [5:0]       power_mode,
  output logic             irq
);

  logic [31:0]        cfg_reg;
  logic [31:0]        pre_reg;
  logic [31:0]        gate_reg;
  logic [31:0]        osc_reg;
  logic [31:0]        stat_reg;
  logic [2:0]         irq_reg;
  logic [2:0]         mask_reg;
  logic [15:0]        wakeen_reg;
  logic [1:0]         sel_reg;
  logic               xfail_hold_reg;
  logic               pll_rdy_q;
  logic [1:0]         want_src;
  logic               want_rdy;
  cpm_pkg::cpm_mode_t mode_reg;
  cpm_pkg::cpm_mode_t mode_next;
  logic [6:0]         wake_cnt_reg;
  logic [1:0]         req;
  logic               stop_rtc;
  logic               stop_evt;
  logic               xfail_evt;
  logic               xfail_det_en;
  logic [24:0]        ext_s1_reg;
  logic [24:0]        ext_s2_reg;
  logic [24:0]        ext_s3_reg;
  logic [3:0]         rdy_s1_reg;
  logic [3:0]         rdy_s2_reg;
  logic               fail_s1_reg;
  logic               fail_s2_reg;
  logic               fail_s3_reg;

  // Pin inputs except cpu_sleep_req pass two flip-flops; wake events and crystal fail pass a third for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_s1_reg  <= 25'h0;
      ext_s2_reg  <= 25'h0;
      ext_s3_reg  <= 25'h0;
      rdy_s1_reg  <= 4'h0;
      rdy_s2_reg  <= 4'h0;
      fail_s1_reg <= 1'b0;
      fail_s2_reg <= 1'b0;
      fail_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg  <= {usb_wakeup, rtc_evt, comparator_evt,
                      supply_voltage_monitor, cpu_irq_evt,
                      external_interrupt_lines};
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      rdy_s1_reg  <= {pll_rdy, multispeed_internal_osc_rdy,
                      fast_internal_osc_rdy, fast_crystal_osc_rdy};
      rdy_s2_reg  <= rdy_s1_reg;
      fail_s1_reg <= crystal_fail;
      fail_s2_reg <= fail_s1_reg;
      fail_s3_reg <= fail_s2_reg;
    end
  end

  assign xfail_det_en = cfg_reg[8];
  assign xfail_evt    = xfail_det_en && fail_s2_reg && !fail_s3_reg
                        && (sel_reg == `CPM_SRC_XTAL ||
                            (sel_reg == `CPM_SRC_PLL && cfg_reg[4]));
  assign stop_rtc = cfg_reg[9];
  // Rising edge on a stop wake source, interrupt lines only when set in wakeen_reg; cpu events do not count
  assign stop_evt = |(ext_s2_reg[24:17] & ~ext_s3_reg[24:17])
                    || |(ext_s2_reg[15:0] & ~ext_s3_reg[15:0]
                         & wakeen_reg);

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_reg    <= `CPM_CFG_RST;
      pre_reg    <= 32'h0;
      gate_reg   <= `CPM_GATE_RST;
      osc_reg    <= `CPM_OSC_RST;
      mask_reg   <= 3'h0;
      wakeen_reg <= 16'hffff;
    end else if (wr_stb) begin
      unique case (addr)
        `CPM_A_CFG:    cfg_reg    <= wdata;
        `CPM_A_PRE:    pre_reg    <= wdata;
        `CPM_A_GATE:   gate_reg   <= wdata;
        `CPM_A_OSC:    osc_reg    <= wdata;
        `CPM_A_MASK:   mask_reg   <= wdata[2:0];
        `CPM_A_WAKEEN: wakeen_reg <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 3'h0;
    end else begin
      irq_reg <= (irq_reg & ~((wr_stb && addr == `CPM_A_IRQ) ?
                              wdata[2:0] : 3'h0))
                 | {mode_reg == cpm_pkg::CPM_WAKING && wake_cnt_reg == 7'h0,
                    1'b0, xfail_evt};
    end
  end

  assign irq = |(irq_reg & mask_reg);

  // Source switch: keep old source until new one is stable; crystal failure moves to fast internal at once
  always_comb begin
    want_src = cfg_reg[1:0];
    if (xfail_hold_reg && want_src != `CPM_SRC_MULTI)
      want_src = `CPM_SRC_FINT;
    want_rdy = rdy_s2_reg[want_src == `CPM_SRC_MULTI ? 2 :
                          want_src == `CPM_SRC_FINT ? 1 :
                          want_src == `CPM_SRC_XTAL ? 0 : 3];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_reg        <= `CPM_SRC_MULTI;
      xfail_hold_reg <= 1'b0;
    end else begin
      if (xfail_evt)
        xfail_hold_reg <= 1'b1;
      else if (wr_stb && addr == `CPM_A_CFG)
        xfail_hold_reg <= 1'b0;
      if (xfail_evt)
        sel_reg <= `CPM_SRC_FINT;
      else if (want_src != sel_reg && want_rdy)
        sel_reg <= want_src;
    end
  end

  assign sys_clk_sel = sel_reg;
  assign ms_osc_range = osc_reg[6:4];

  // Power mode sequencer
  assign req = cfg_reg[11:10];

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      cpm_pkg::CPM_RUN, cpm_pkg::CPM_LP_RUN:
        if (cpu_sleep_req) begin
          if (req == cpm_pkg::CPM_REQ_STOP)
            mode_next = cpm_pkg::CPM_STOP;
          else if (mode_reg == cpm_pkg::CPM_LP_RUN)
            mode_next = cpm_pkg::CPM_LP_SLEEP;
          else
            mode_next = cpm_pkg::CPM_SLEEP;
        end else if (req == cpm_pkg::CPM_REQ_LPRUN
                     && ms_osc_range <= `CPM_MS_LP_MAX) begin
          mode_next = cpm_pkg::CPM_LP_RUN;
        end else if (req != cpm_pkg::CPM_REQ_LPRUN) begin
          mode_next = cpm_pkg::CPM_RUN;
        end
      cpm_pkg::CPM_SLEEP:
        if (ext_s2_reg != 25'h0)
          mode_next = cpm_pkg::CPM_RUN;
      cpm_pkg::CPM_LP_SLEEP:
        if (ext_s2_reg != 25'h0)
          mode_next = cpm_pkg::CPM_RUN;
      cpm_pkg::CPM_STOP:
        if (stop_evt)
          mode_next = cpm_pkg::CPM_WAKING;
      cpm_pkg::CPM_WAKING:
        if (wake_cnt_reg == 7'h0)
          mode_next = cpm_pkg::CPM_RUN;
      default:
        mode_next = cpm_pkg::CPM_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      mode_reg <= cpm_pkg::CPM_RUN;
    else
      mode_reg <= mode_next;
  end

  // Wakeup completes within the stop wake time
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      wake_cnt_reg <= 7'h0;
    else if (mode_reg == cpm_pkg::CPM_STOP)
      wake_cnt_reg <= `CPM_WAKE_NUM - 7'h2;
    else if (wake_cnt_reg != 7'h0)
      wake_cnt_reg <= wake_cnt_reg - 7'h1;
  end

  assign power_mode = mode_reg;

  // Oscillator enables, gating and clock tree selects
  always_comb begin
    fast_crystal_osc_en        = osc_reg[1] || sel_reg == `CPM_SRC_XTAL
                                 || cfg_reg[1:0] == `CPM_SRC_XTAL;
    fast_internal_osc_en       = osc_reg[2] || xfail_hold_reg
                                 || sel_reg == `CPM_SRC_FINT
                                 || cfg_reg[1:0] == `CPM_SRC_FINT;
    multispeed_internal_osc_en = osc_reg[0] || sel_reg == `CPM_SRC_MULTI
                                 || cfg_reg[1:0] == `CPM_SRC_MULTI;
    pll_en                     = osc_reg[3] || sel_reg == `CPM_SRC_PLL
                                 || cfg_reg[1:0] == `CPM_SRC_PLL;
    slow_crystal_osc_en        = osc_reg[7];
    slow_internal_osc_en       = osc_reg[8];
    cpu_clk_en                 = gate_reg[16];
    periph_clk_en              = gate_reg[15:0];
    mem_clk_en                 = gate_reg[17];
    unique case (mode_reg)
      cpm_pkg::CPM_SLEEP, cpm_pkg::CPM_LP_SLEEP:
        cpu_clk_en = 1'b0;
      cpm_pkg::CPM_STOP: begin
        cpu_clk_en                 = 1'b0;
        periph_clk_en              = 16'h0;
        mem_clk_en                 = 1'b0;
        fast_crystal_osc_en        = 1'b0;
        fast_internal_osc_en       = 1'b0;
        multispeed_internal_osc_en = 1'b0;
        pll_en                     = 1'b0;
        slow_crystal_osc_en        = stop_rtc && osc_reg[7];
        slow_internal_osc_en       = stop_rtc && osc_reg[8];
      end
      default: ;
    endcase
  end

  assign pll_rdy_q    = rdy_s2_reg[3];
  assign usb_clk_en   = pll_en && pll_rdy_q && cfg_reg[12];
  assign rtc_clk_sel  = cfg_reg[14:13];
  assign clock_output_pin_sel = cfg_reg[18:16];
  assign regulator_lp = mode_reg == cpm_pkg::CPM_LP_RUN
                        || mode_reg == cpm_pkg::CPM_LP_SLEEP
                        || mode_reg == cpm_pkg::CPM_STOP;
  // Prescaler codes are divide by 2**code
  assign ahb_div      = pre_reg[2:0];
  assign apb_fast_div = pre_reg[6:4];
  assign apb_slow_div = pre_reg[10:8];

  always_comb begin
    stat_reg = {19'h0, mode_reg, xfail_hold_reg, rdy_s2_reg, sel_reg};
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (rd_stb) begin
      unique case (addr)
        `CPM_A_CFG:    rdata <= cfg_reg;
        `CPM_A_PRE:    rdata <= pre_reg;
        `CPM_A_GATE:   rdata <= gate_reg;
        `CPM_A_OSC:    rdata <= osc_reg;
        `CPM_A_MODE:   rdata <= {26'h0, mode_reg};
        `CPM_A_STAT:   rdata <= stat_reg;
        `CPM_A_IRQ:    rdata <= {29'h0, irq_reg};
        `CPM_A_MASK:   rdata <= {29'h0, mask_reg};
        `CPM_A_WAKEEN: rdata <= {16'h0, wakeen_reg};
        default:       rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule // cpm_ctrl

// [core/cpm_consts.svh]
// Purpose: Offsets, fields, reset values and timing counts of the clock
//          and power mode controller.
// Assumes: Included by core/cpm_ctrl.sv only.
// Notes:   Register offsets are word indices on the plain register port.
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

`define CPM_A_CFG      4'h0
`define CPM_A_PRE      4'h1
`define CPM_A_GATE     4'h2
`define CPM_A_OSC      4'h3
`define CPM_A_MODE     4'h4
`define CPM_A_STAT     4'h5
`define CPM_A_IRQ      4'h6
`define CPM_A_MASK     4'h7
`define CPM_A_WAKEEN   4'h8

`define CPM_SRC_MULTI  2'h0
`define CPM_SRC_FINT   2'h1
`define CPM_SRC_XTAL   2'h2
`define CPM_SRC_PLL    2'h3

`define CPM_MS_RST     3'h5
`define CPM_MS_MIN     3'h0
`define CPM_MS_LP_MAX  3'h1
`define CPM_CFG_RST    32'h0000_0000
`define CPM_GATE_RST   32'hffff_ffff
`define CPM_OSC_RST    32'h0000_0051

`define CPM_IRQ_XFAIL  0
`define CPM_IRQ_SW     1
`define CPM_IRQ_WAKE   2

`define CPM_PRE_MAX    3'h7
`define CPM_WAKE_US    8
`define CPM_CLK_MHZ    10
`define CPM_WAKE_CYC   (`CPM_WAKE_US * `CPM_CLK_MHZ)
`define CPM_WAKE_NUM   7'(`CPM_WAKE_CYC)

`endif

// [core/cpm_pkg.sv]
// Purpose: Types of the clock and power mode controller.
// Assumes: Nothing beyond the header of constants.
// Notes:   Power mode states are one-hot.
package cpm_pkg;
  typedef enum logic [5:0] {
    CPM_RUN      = 6'h01,
    CPM_SLEEP    = 6'h02,
    CPM_LP_RUN   = 6'h04,
    CPM_LP_SLEEP = 6'h08,
    CPM_STOP     = 6'h10,
    CPM_WAKING   = 6'h20
  } cpm_mode_t;

  typedef enum logic [1:0] {
    CPM_REQ_NONE  = 2'h0,
    CPM_REQ_SLEEP = 2'h1,
    CPM_REQ_STOP  = 2'h2,
    CPM_REQ_LPRUN = 2'h3
  } cpm_req_t;
endpackage

// [verif/cpm_ctrl_asserts.sv]
// Purpose: Port checks of the clock and power mode controller.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to cpm_ctrl at the foot of this file.
`timescale 1ns/1ps
module cpm_ctrl_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        fast_crystal_osc_rdy,
  input wire logic        pll_rdy,
  input wire logic        cpu_irq_evt,
  input wire logic [15:0] external_interrupt_lines,
  input wire logic [1:0]  sys_clk_sel,
  input wire logic        fast_crystal_osc_en,
  input wire logic        fast_internal_osc_en,
  input wire logic        multispeed_internal_osc_en,
  input wire logic        pll_en,
  input wire logic        usb_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic        regulator_lp,
  input wire logic [5:0]  power_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_reset_state: assert property (
    $fell(reset) |-> sys_clk_sel == 2'h0 && power_mode == cpm_pkg::CPM_RUN)
    else $error("source or mode wrong after reset");
  chk_stop_osc_off: assert property (
    power_mode == cpm_pkg::CPM_STOP |-> regulator_lp && !(pll_en ||
    fast_crystal_osc_en || fast_internal_osc_en ||
    multispeed_internal_osc_en || cpu_clk_en))
    else $error("clock or oscillator running in stop");
  chk_stop_line_wake: assert property (
    power_mode == cpm_pkg::CPM_STOP && |external_interrupt_lines |->
    ##[1:6] power_mode != cpm_pkg::CPM_STOP)
    else $error("line did not end stop");
  chk_wake_time: assert property (
    $rose(power_mode == cpm_pkg::CPM_WAKING) |->
    ##[1:80] power_mode == cpm_pkg::CPM_RUN)
    else $error("wakeup too long");
  chk_lp_wake_reg: assert property (
    $past(power_mode) == cpm_pkg::CPM_LP_SLEEP &&
    power_mode == cpm_pkg::CPM_RUN |-> !regulator_lp)
    else $error("regulator still low power after wake");
  chk_crystal_rdy_first: assert property (
    $changed(sys_clk_sel) && sys_clk_sel == 2'h2 |->
    $past(fast_crystal_osc_rdy, 2))
    else $error("switched to crystal before ready");
  chk_pll_rdy_first: assert property (
    $changed(sys_clk_sel) && sys_clk_sel == 2'h3 |-> $past(pll_rdy, 2))
    else $error("switched to pll before ready");
  chk_sleep_cpu_off: assert property (
    power_mode == cpm_pkg::CPM_SLEEP |-> !cpu_clk_en)
    else $error("cpu clock running in sleep");
  chk_sleep_exit: assert property (
    power_mode == cpm_pkg::CPM_SLEEP && cpu_irq_evt |->
    ##[1:5] power_mode != cpm_pkg::CPM_SLEEP)
    else $error("event did not end sleep");
  chk_usb_from_pll: assert property (
    usb_clk_en |-> pll_en)
    else $error("usb clock without pll");
endmodule // cpm_ctrl_chk

bind cpm_ctrl cpm_ctrl_chk u_cpm_ctrl_chk (
  .clk, .reset, .fast_crystal_osc_rdy, .pll_rdy, .cpu_irq_evt,
  .external_interrupt_lines, .sys_clk_sel, .fast_crystal_osc_en,
  .fast_internal_osc_en, .multispeed_internal_osc_en, .pll_en, .usb_clk_en,
  .cpu_clk_en, .regulator_lp, .power_mode
);

// [verif/cpm_osc_model.sv]
// Purpose: Oscillators and pll answering enables with ready levels.
// Assumes: Bit order multispeed, crystal, fast internal, pll.
// Notes:   Ready drops at once on disable or crystal failure.
`timescale 1ns/1ps
module cpm_osc_model #(
  parameter int START = 4
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] en,
  input  wire logic       fail,
  input  wire logic       slow,
  output logic      [3:0] rdy
);
  logic [4:0] cnt [4];

  // Start-up count per oscillator, long when slow is set
  always_ff @(posedge clk or posedge reset) begin
    for (int i = 0; i < 4; i++) begin
      if (reset || !en[i] || (i == 1 && fail)) begin
        cnt[i] <= 5'h0;
        rdy[i] <= 1'b0;
      end else if (cnt[i] < (slow ? 5'h10 : 5'(START))) begin
        cnt[i] <= cnt[i] + 5'h1;
      end else begin
        rdy[i] <= 1'b1;
      end
    end
  end
endmodule // cpm_osc_model

// [verif/tb_top.sv]
// Purpose: Self-checking bench of the clock and power mode controller.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Oscillators come from cpm_osc_model.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        crystal_fail = 1'b0;
  logic        cpu_irq_evt = 1'b0;
  logic        cpu_sleep_req = 1'b0;
  logic        slow = 1'b0;
  logic [23:0] wake = 24'h0;
  logic [3:0]  rdy;
  logic [31:0] rdata;
  logic [5:0]  power_mode;
  logic [15:0] periph_clk_en;
  logic [2:0]  ms_osc_range, ahb_div, apb_fast_div, apb_slow_div;
  logic [2:0]  clock_output_pin_sel;
  logic [1:0]  sys_clk_sel, rtc_clk_sel;
  logic        fast_crystal_osc_en, fast_internal_osc_en, pll_en;
  logic        multispeed_internal_osc_en, usb_clk_en, regulator_lp;
  logic        slow_crystal_osc_en, slow_internal_osc_en, irq;
  logic        cpu_clk_en, mem_clk_en;
  int          bad_count = 0;
  int          total_checks = 0;

  always #50 clk = ~clk;

  cpm_osc_model u_cpm_osc_model (.clk, .reset, .fail(crystal_fail), .slow,
    .en({pll_en, fast_internal_osc_en, fast_crystal_osc_en,
    multispeed_internal_osc_en}), .rdy);

  cpm_ctrl u_cpm_ctrl (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .fast_crystal_osc_rdy(rdy[1]), .fast_internal_osc_rdy(rdy[2]),
    .multispeed_internal_osc_rdy(rdy[0]), .pll_rdy(rdy[3]), .crystal_fail,
    .external_interrupt_lines(wake[15:0]), .supply_voltage_monitor(wake[16]),
    .comparator_evt(wake[18:17]), .rtc_evt(wake[22:19]),
    .usb_wakeup(wake[23]), .cpu_irq_evt, .cpu_sleep_req, .sys_clk_sel,
    .ms_osc_range, .fast_crystal_osc_en, .fast_internal_osc_en,
    .multispeed_internal_osc_en, .slow_crystal_osc_en, .slow_internal_osc_en,
    .pll_en, .usb_clk_en, .rtc_clk_sel, .ahb_div, .apb_fast_div,
    .apb_slow_div, .cpu_clk_en, .periph_clk_en, .mem_clk_en,
    .clock_output_pin_sel, .regulator_lp, .power_mode, .irq);

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  task automatic wait_mode(input logic [5:0] m, input int lim);
    for (int n = 0; n < lim && power_mode !== m; n++) begin
      @(posedge clk);
      #1;
    end
    chk("power_mode", 32'(m), 32'(power_mode));
  endtask

  task automatic wait_sel(input logic [1:0] s, input int lim);
    for (int n = 0; n < lim && sys_clk_sel !== s; n++) begin
      @(posedge clk);
      #1;
    end
    chk("sys_clk_sel", 32'(s), 32'(sys_clk_sel));
  endtask

  task automatic t_reset();
    chk("sys_clk_sel", 32'h0, 32'(sys_clk_sel));
    chk("ms_osc_en", 32'h1, 32'(multispeed_internal_osc_en));
    chk("ms_osc_range", 32'h5, 32'(ms_osc_range));
    chk("irq", 32'h0, 32'(irq));
    rd(4'h2, 32'hffff_ffff, "gate_reg");
    rd(4'h3, 32'h0000_0051, "osc_reg");
    wr(4'hf, 32'h1234_5678);
    rd(4'hf, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_switch();
    logic [1:0] prev;
    prev = 2'h0;
    slow <= 1'b1;
    wr(4'h3, 32'h0000_000f);
    for (int s = 1; s < 5; s++) begin
      wr(4'h0, 32'(s % 4));
      chk("sel_hold", 32'(prev), 32'(sys_clk_sel));
      wait_sel(2'(s % 4), 40);
      prev = 2'(s % 4);
    end
    slow <= 1'b0;
    for (int r = 0; r < 7; r++) begin
      wr(4'h3, 32'h0000_000f | 32'(r << 4));
      chk("ms_osc_range", 32'(r), 32'(ms_osc_range));
    end
    wr(4'h3, 32'h0000_005f);
    $display("test switch done");
  endtask

  task automatic t_css();
    wr(4'h0, 32'h0000_0102);
    wait_sel(2'h2, 40);
    @(posedge clk);
    crystal_fail <= 1'b1;
    wait_sel(2'h1, 10);
    chk("irq_masked", 32'h0, 32'(irq));
    rd(4'h6, 32'h0000_0001, "irq_reg");
    wr(4'h7, 32'h0000_0001);
    @(posedge clk);
    crystal_fail <= 1'b0;
    chk("irq_on", 32'h1, 32'(irq));
    wr(4'h6, 32'h0000_0001);
    @(posedge clk);
    chk("irq_clear", 32'h0, 32'(irq));
    $display("test css done");
  endtask

  task automatic t_fields();
    wr(4'h1, 32'h0000_0321);
    wr(4'h2, 32'h0002_a5a5);
    wr(4'h0, 32'h0005_5000);
    chk("dividers", 32'h321, {21'h0, apb_slow_div, 1'b0, apb_fast_div, 1'b0,
        ahb_div});
    chk("gates", 32'h2a5a5, {14'h0, mem_clk_en, cpu_clk_en, periph_clk_en});
    chk("rtc_sel", 32'h2, 32'(rtc_clk_sel));
    chk("clk_out_sel", 32'h5, 32'(clock_output_pin_sel));
    chk("usb_clk", 32'h1, 32'(usb_clk_en));
    wr(4'h2, 32'hffff_ffff);
    $display("test fields done");
  endtask

  task automatic t_sleep();
    wr(4'h0, 32'h0000_0400);
    @(posedge clk);
    cpu_sleep_req <= 1'b1;
    wait_mode(cpm_pkg::CPM_SLEEP, 10);
    chk("periph_run", 32'hffff, 32'(periph_clk_en));
    @(posedge clk);
    cpu_sleep_req <= 1'b0;
    cpu_irq_evt <= 1'b1;
    wait_mode(cpm_pkg::CPM_RUN, 10);
    @(posedge clk);
    cpu_irq_evt <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_lp();
    wr(4'h3, 32'h0000_000f);
    wr(4'h0, 32'h0000_0c00);
    wait_mode(cpm_pkg::CPM_LP_RUN, 10);
    chk("regulator_lp", 32'h1, 32'(regulator_lp));
    @(posedge clk);
    cpu_sleep_req <= 1'b1;
    wait_mode(cpm_pkg::CPM_LP_SLEEP, 10);
    chk("lp_cpu_clk", 32'h0, 32'(cpu_clk_en));
    @(posedge clk);
    cpu_sleep_req <= 1'b0;
    cpu_irq_evt <= 1'b1;
    wait_mode(cpm_pkg::CPM_RUN, 10);
    chk("regulator_run", 32'h0, 32'(regulator_lp));
    @(posedge clk);
    cpu_irq_evt <= 1'b0;
    wr(4'h0, 32'h0000_0000);
    wait_mode(cpm_pkg::CPM_RUN, 10);
    $display("test low power done");
  endtask

  task automatic t_stop();
    int src [6] = '{0, 15, 16, 17, 19, 23};
    wr(4'h3, 32'h0000_01df);
    for (int k = 0; k < 6; k++) begin
      wr(4'h0, (k == 0) ? 32'h0000_0800 : 32'h0000_0a00);
      @(posedge clk);
      cpu_sleep_req <= 1'b1;
      wait_mode(cpm_pkg::CPM_STOP, 10);
      chk("fast_osc", 32'h0, {28'h0, pll_en, fast_crystal_osc_en,
          fast_internal_osc_en, multispeed_internal_osc_en});
      chk("slow_osc", (k == 0) ? 32'h0 : 32'h3, {30'h0, slow_crystal_osc_en,
          slow_internal_osc_en});
      @(posedge clk);
      cpu_sleep_req <= 1'b0;
      wake <= 24'h1 << src[k];
      wait_mode(cpm_pkg::CPM_RUN, 90);
      @(posedge clk);
      wake <= 24'h0;
    end
    rd(4'h6, 32'h0000_0004, "wake_flag");
    $display("test stop done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_switch();
    t_css();
    t_fields();
    t_sleep();
    t_lp();
    t_stop();
    results();
  end
endmodule // tb_top
